// ==== pior_map.vh ====
`ifndef PIOR_MAP_VH
`define PIOR_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PIOR_OFF_CTRL      12'h000
`define PIOR_OFF_STATUS    12'h004
`define PIOR_OFF_IRQ_STAT  12'h008
`define PIOR_OFF_IRQ_MASK  12'h00C
`define PIOR_OFF_VOLTAGE   12'h010
`define PIOR_OFF_WIN_LOW   12'h014
`define PIOR_OFF_WIN_HIGH  12'h018
`define PIOR_OFF_FHOLD     12'h01C
`define PIOR_OFF_BHOLD     12'h020
`define PIOR_OFF_FAULT     12'h024
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define PIOR_CTRL_MODE_LSB 0
`define PIOR_CTRL_MODE_MSB 1
`define PIOR_CTRL_MODE_RST 2'b00
`define PIOR_MODE_LATCHED  2'b00
`define PIOR_MODE_LATCHALT 2'b01
`define PIOR_MODE_TIMED    2'b10
// ---------------------------------------------------------------
// fault event register fields (write one to raise)
// ---------------------------------------------------------------
`define PIOR_FLT_ANY       0
`define PIOR_FLT_BARE      1
`define PIOR_FLT_PANEL_CLR 2
// ---------------------------------------------------------------
// interrupt bits
// ---------------------------------------------------------------
`define PIOR_IRQ_FAULT     0
`define PIOR_IRQ_BARE      1
`define PIOR_IRQ_PERMIT    2
`define PIOR_IRQ_CLEAR     3
`define PIOR_IRQ_W         4
// ---------------------------------------------------------------
// thresholds, times, resets
// ---------------------------------------------------------------
`define PIOR_HV_PRESENT_V  16'd500
`define PIOR_WIN_LOW_RST   16'h0000
`define PIOR_WIN_HIGH_RST  16'hFFFF
`define PIOR_HOLD_RST      16'h000A
`define PIOR_CLK_HZ        10000000
`define PIOR_CLEAR_MIN_MS  50
`define PIOR_PERMIT_MS     5
`define PIOR_MS_DIV        10000
`endif

// ==== pior_debounce.v ====
`timescale 1ns/100ps
`include "pior_map.vh"
module pior_debounce #(
  parameter CNT_W  = 20,
  parameter STABLE = 1000
) (
  // clock and reset
  input  wire CLK_I,
  input  wire SRST_I,
  // contact
  input  wire pin_i,
  output reg  level_o,
  output reg  rise_o,
  output reg  fall_o
);
  reg             s1_ff;
  reg             s2_ff;
  reg             s3_ff;
  reg [CNT_W-1:0] cnt_ff;

  // ---------------------------------------------------------------
  // three-stage sync; change counts when stages two and three agree
  // ---------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      cnt_ff  <= {CNT_W{1'b0}};
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      s1_ff  <= pin_i;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      // level must stay stable longer than the minimum before it is taken
      if (s2_ff != s3_ff || s3_ff == level_o) begin
        cnt_ff <= {CNT_W{1'b0}};
      end else if (cnt_ff == STABLE[CNT_W-1:0]) begin
        cnt_ff  <= {CNT_W{1'b0}};
        level_o <= s3_ff;
        rise_o  <= s3_ff;
        fall_o  <= ~s3_ff;
      end else begin
        cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== pior_alarm.v ====
`timescale 1ns/100ps
`include "pior_map.vh"
module pior_alarm (
  // clock and reset
  input  wire        CLK_I,
  input  wire        SRST_I,
  // control
  input  wire        ms_tick_i,
  input  wire [1:0]  mode_i,
  input  wire [15:0] hold_ms_i,
  input  wire        fault_i,
  input  wire        clear_i,
  // relay
  output reg         relay_o
);
  reg [15:0] left_ff;
  wire       timed = (mode_i == `PIOR_MODE_TIMED);

  // ---------------------------------------------------------------
  // latched modes wait for a clear; timed mode counts down in ms
  // ---------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      relay_o <= 1'b0;
      left_ff <= 16'h0000;
    end else if (fault_i) begin
      // a new fault wins over a clear in the same cycle
      relay_o <= 1'b1;
      left_ff <= hold_ms_i;
    end else if (relay_o && !timed && clear_i) begin
      relay_o <= 1'b0;
    end else if (relay_o && timed && ms_tick_i) begin
      if (left_ff <= 16'h0001) begin
        relay_o <= 1'b0;
        left_ff <= 16'h0000;
      end else begin
        left_ff <= left_ff - 16'h0001;
      end
    end
  end
endmodule

// ==== pior_top.v ====
// Functional notes
// RULE_01: high voltage is applied only while the permit contact stays closed; the code keeps it on until the opened contact has passed the debounce time.
// RULE_02: the outside party opens the permit contact when the line stops.
// RULE_03: a remote clear closure returns the fault relay to normal; in timed mode the code ignores the clear.
// RULE_04: the outside party holds the clear contact closed longer than 50 ms.
// RULE_05: hv present relay closes while measured voltage is above 500 V.
// RULE_06: any detected test fault activates the fault alarm relay.
// RULE_07: latched modes keep the fault relay until panel or remote clear.
// RULE_08: timed mode releases the fault relay after its hold time.
// RULE_09: window relay closes only while voltage lies between low and high.
// RULE_10: a bare conductor fault activates its own relay independently.
// RULE_11: latched modes keep the bare relay until panel or remote clear.
// RULE_12: timed mode releases the bare relay after its hold time.
// RULE_13: both contacts are synchronised and debounced by a counter.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "pior_map.vh"
module pior_top #(
  parameter CLEAR_CYC  = (`PIOR_CLK_HZ / 1000) * `PIOR_CLEAR_MIN_MS,
  parameter PERMIT_CYC = (`PIOR_CLK_HZ / 1000) * `PIOR_PERMIT_MS,
  parameter MS_DIV     = `PIOR_MS_DIV
) (
  // clock and reset
  input  wire        CLK_I,
  input  wire        SRST_I,
  // apb slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // contacts
  input  wire        HV_PERMIT_INPUT_I,
  input  wire        REMOTE_CLEAR_INPUT_I,
  // relays and high voltage control
  output reg         HV_DRIVE_O,
  output reg         HV_PRESENT_RELAY_O,
  output reg         FAULT_ALARM_RELAY_O,
  output reg         VOLTAGE_WINDOW_RELAY_O,
  output reg         BARE_CONDUCTOR_RELAY_O,
  // interrupt
  output reg         IRQ_O
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg [1:0]           mode_ff;
  reg [15:0]          volt_ff;
  reg [15:0]          win_low_ff;
  reg [15:0]          win_high_ff;
  reg [15:0]          fhold_ff;
  reg [15:0]          bhold_ff;
  reg                 any_evt_ff;
  reg                 bare_evt_ff;
  reg                 panel_clr_ff;
  reg [`PIOR_IRQ_W-1:0] irq_stat_ff;
  reg [`PIOR_IRQ_W-1:0] irq_mask_ff;
  reg [13:0]          div_ff;
  reg                 ms_tick_ff;
  reg [31:0]          nxt_rdata;
  wire                permit_lvl;
  wire                permit_rise;
  wire                permit_fall;
  wire                clear_lvl;
  wire                clear_rise;
  wire                fault_rly;
  wire                bare_rly;
  wire                wr_acc;
  wire                rd_acc;
  wire                hit;
  wire                clear_any;
  wire [`PIOR_IRQ_W-1:0] irq_set;
  wire                stat_wr;
  reg                 nxt_hv_drive;
  reg                 nxt_present;
  reg                 nxt_window;
  reg                 nxt_fault_rly;
  reg                 nxt_bare_rly;
  reg [`PIOR_IRQ_W-1:0] nxt_irq_stat;

  function in_map;
    input [11:0] a;
    begin
      in_map = (a[1:0] == 2'b00) && (a <= `PIOR_OFF_FAULT);
    end
  endfunction

  // ---------------------------------------------------------------
  // contact inputs
  // ---------------------------------------------------------------
  pior_debounce #(.CNT_W(20), .STABLE(PERMIT_CYC)) u_permit ( // RULE_13
    .CLK_I   (CLK_I),
    .SRST_I  (SRST_I),
    .pin_i   (HV_PERMIT_INPUT_I),
    .level_o (permit_lvl),
    .rise_o  (permit_rise),
    .fall_o  (permit_fall)
  );

  // a clear is accepted only once held longer than the minimum
  pior_debounce #(.CNT_W(20), .STABLE(CLEAR_CYC + 1)) u_clear ( // RULE_13
    .CLK_I   (CLK_I),
    .SRST_I  (SRST_I),
    .pin_i   (REMOTE_CLEAR_INPUT_I),
    .level_o (clear_lvl),
    .rise_o  (clear_rise),
    .fall_o  ()
  );

  assign clear_any = clear_rise | panel_clr_ff; // RULE_03

  // ---------------------------------------------------------------
  // millisecond enable
  // ---------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      div_ff     <= 14'h0000;
      ms_tick_ff <= 1'b0;
    end else if (div_ff == MS_DIV[13:0] - 14'h0001) begin
      div_ff     <= 14'h0000;
      ms_tick_ff <= 1'b1;
    end else begin
      div_ff     <= div_ff + 14'h0001;
      ms_tick_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // alarm relays
  // ---------------------------------------------------------------
  pior_alarm u_fault ( // RULE_06 RULE_07 RULE_08
    .CLK_I     (CLK_I),
    .SRST_I    (SRST_I),
    .ms_tick_i (ms_tick_ff),
    .mode_i    (mode_ff),
    .hold_ms_i (fhold_ff),
    .fault_i   (any_evt_ff),
    .clear_i   (clear_any),
    .relay_o   (fault_rly)
  );

  pior_alarm u_bare ( // RULE_10 RULE_11 RULE_12
    .CLK_I     (CLK_I),
    .SRST_I    (SRST_I),
    .ms_tick_i (ms_tick_ff),
    .mode_i    (mode_ff),
    .hold_ms_i (bhold_ff),
    .fault_i   (bare_evt_ff),
    .clear_i   (clear_any),
    .relay_o   (bare_rly)
  );

  // ---------------------------------------------------------------
  // relay outputs
  // ---------------------------------------------------------------
  always @* begin
    // supply is dropped once the permit contact has stayed open for the debounce time
    nxt_hv_drive  = permit_lvl; // RULE_01 RULE_02
    nxt_present   = (volt_ff > `PIOR_HV_PRESENT_V); // RULE_05
    nxt_window    = (volt_ff >= win_low_ff) && (volt_ff <= win_high_ff); // RULE_09
    nxt_fault_rly = fault_rly;
    nxt_bare_rly  = bare_rly;
  end

  // every relay pin comes from a flop so no decode glitch reaches a contact
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      HV_DRIVE_O             <= 1'b0;
      HV_PRESENT_RELAY_O     <= 1'b0;
      FAULT_ALARM_RELAY_O    <= 1'b0;
      VOLTAGE_WINDOW_RELAY_O <= 1'b0;
      BARE_CONDUCTOR_RELAY_O <= 1'b0;
    end else begin
      HV_DRIVE_O             <= nxt_hv_drive;
      HV_PRESENT_RELAY_O     <= nxt_present;
      FAULT_ALARM_RELAY_O    <= nxt_fault_rly;
      VOLTAGE_WINDOW_RELAY_O <= nxt_window;
      BARE_CONDUCTOR_RELAY_O <= nxt_bare_rly;
    end
  end

  // ---------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped or misaligned
  // ---------------------------------------------------------------
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_acc = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign hit    = in_map(PADDR_I);

  assign irq_set = {clear_rise, permit_fall | permit_rise, bare_evt_ff, any_evt_ff};

  // ---------------------------------------------------------------
  // interrupt status: sticky, write one to clear, set wins
  // ---------------------------------------------------------------
  assign stat_wr = wr_acc & (PADDR_I == `PIOR_OFF_IRQ_STAT);

  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (stat_wr) begin
      nxt_irq_stat = nxt_irq_stat & ~PWDATA_I[`PIOR_IRQ_W-1:0];
    end
    // an event in the same cycle as its clear must not be lost
    nxt_irq_stat = nxt_irq_stat | irq_set;
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_ff     <= `PIOR_CTRL_MODE_RST;
      volt_ff     <= 16'h0000;
      win_low_ff  <= `PIOR_WIN_LOW_RST;
      win_high_ff <= `PIOR_WIN_HIGH_RST;
      fhold_ff    <= `PIOR_HOLD_RST;
      bhold_ff    <= `PIOR_HOLD_RST;
      irq_stat_ff <= {`PIOR_IRQ_W{1'b0}};
      irq_mask_ff <= {`PIOR_IRQ_W{1'b0}};
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_acc && hit) begin
        case (PADDR_I)
          `PIOR_OFF_CTRL:     mode_ff     <= PWDATA_I[`PIOR_CTRL_MODE_MSB:`PIOR_CTRL_MODE_LSB];
          `PIOR_OFF_IRQ_MASK: irq_mask_ff <= PWDATA_I[`PIOR_IRQ_W-1:0];
          `PIOR_OFF_VOLTAGE:  volt_ff     <= PWDATA_I[15:0];
          `PIOR_OFF_WIN_LOW:  win_low_ff  <= PWDATA_I[15:0];
          `PIOR_OFF_WIN_HIGH: win_high_ff <= PWDATA_I[15:0];
          `PIOR_OFF_FHOLD:    fhold_ff    <= PWDATA_I[15:0];
          `PIOR_OFF_BHOLD:    bhold_ff    <= PWDATA_I[15:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // fault events: write-one pulses that stand for a single cycle
  // ---------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      any_evt_ff   <= 1'b0;
      bare_evt_ff  <= 1'b0;
      panel_clr_ff <= 1'b0;
    end else if (wr_acc && PADDR_I == `PIOR_OFF_FAULT) begin
      // a bare conductor fault is also a test fault
      any_evt_ff   <= PWDATA_I[`PIOR_FLT_ANY] | PWDATA_I[`PIOR_FLT_BARE];
      bare_evt_ff  <= PWDATA_I[`PIOR_FLT_BARE];
      panel_clr_ff <= PWDATA_I[`PIOR_FLT_PANEL_CLR];
    end else begin
      any_evt_ff   <= 1'b0;
      bare_evt_ff  <= 1'b0;
      panel_clr_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (PADDR_I)
      `PIOR_OFF_CTRL:     nxt_rdata[1:0]  = mode_ff;
      `PIOR_OFF_STATUS:   nxt_rdata[6:0]  = {clear_lvl, permit_lvl, BARE_CONDUCTOR_RELAY_O,
                                             VOLTAGE_WINDOW_RELAY_O, FAULT_ALARM_RELAY_O,
                                             HV_PRESENT_RELAY_O, HV_DRIVE_O};
      `PIOR_OFF_IRQ_STAT: nxt_rdata[`PIOR_IRQ_W-1:0] = irq_stat_ff;
      `PIOR_OFF_IRQ_MASK: nxt_rdata[`PIOR_IRQ_W-1:0] = irq_mask_ff;
      `PIOR_OFF_VOLTAGE:  nxt_rdata[15:0] = volt_ff;
      `PIOR_OFF_WIN_LOW:  nxt_rdata[15:0] = win_low_ff;
      `PIOR_OFF_WIN_HIGH: nxt_rdata[15:0] = win_high_ff;
      `PIOR_OFF_FHOLD:    nxt_rdata[15:0] = fhold_ff;
      `PIOR_OFF_BHOLD:    nxt_rdata[15:0] = bhold_ff;
      default:            nxt_rdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // bus response and interrupt line
  // ---------------------------------------------------------------
  // ready is raised in the setup cycle so the access phase ends at once
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      IRQ_O     <= 1'b0;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit;
      if (rd_acc) begin
        PRDATA_O <= hit ? nxt_rdata : 32'h0000_0000;
      end
      IRQ_O <= |(irq_stat_ff & irq_mask_ff);
    end
  end
endmodule

// ==== pior_top_properties.sv ====
`timescale 1ns/100ps
`include "pior_map.vh"
module pior_top_chk #(
  parameter PERMIT_CYC = 10
) (
  input wire        CLK_I,
  input wire        SRST_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire        PREADY_O,
  input wire        HV_PERMIT_INPUT_I,
  input wire        HV_DRIVE_O,
  input wire        HV_PRESENT_RELAY_O,
  input wire        FAULT_ALARM_RELAY_O,
  input wire        VOLTAGE_WINDOW_RELAY_O,
  input wire        BARE_CONDUCTOR_RELAY_O
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  wire       acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  wire       fwr = acc & (PADDR_I == `PIOR_OFF_FAULT);
  wire       bwr = fwr & PWDATA_I[`PIOR_FLT_BARE];
  // wide enough for the full permit debounce count, saturating
  reg [23:0] hi_ff;
  reg [23:0] lo_ff;
  // relays that follow registers may only move shortly after a write or reset
  reg  [3:0] wr_ff;
  always @(posedge CLK_I) begin
    wr_ff <= {wr_ff[2:0], acc | SRST_I};
    if (SRST_I) begin
      hi_ff <= 24'h00_0000;
      lo_ff <= 24'h00_0000;
    end else begin
      hi_ff <= !HV_PERMIT_INPUT_I ? 24'h00_0000 : (&hi_ff ? hi_ff : hi_ff + 24'h00_0001);
      lo_ff <= HV_PERMIT_INPUT_I ? 24'h00_0000 : (&lo_ff ? lo_ff : lo_ff + 24'h00_0001);
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_hv_rise_permit: assert property ($rose(HV_DRIVE_O) |-> hi_ff >= PERMIT_CYC)
    else $error("hv drive rose without a settled permit");
  a_hv_drop_open: assert property (lo_ff >= PERMIT_CYC + 8 |-> !HV_DRIVE_O)
    else $error("hv drive stays on with permit open");
  a_fault_relay_raise: assert property (fwr && PWDATA_I[`PIOR_FLT_ANY] |-> ##3 FAULT_ALARM_RELAY_O)
    else $error("fault relay not raised");
  a_bare_relay_raise: assert property (bwr |-> ##3 (BARE_CONDUCTOR_RELAY_O && FAULT_ALARM_RELAY_O))
    else $error("bare relay not raised");
  a_fault_rise_cause: assert property ($rose(FAULT_ALARM_RELAY_O) |-> $past(fwr, 3))
    else $error("fault relay rose without an event");
  a_bare_rise_cause: assert property ($rose(BARE_CONDUCTOR_RELAY_O) |-> $past(bwr, 3))
    else $error("bare relay rose without an event");
  a_window_move_cause: assert property ($changed(VOLTAGE_WINDOW_RELAY_O) |-> |wr_ff)
    else $error("window relay moved without a write");
  a_present_move_cause: assert property ($changed(HV_PRESENT_RELAY_O) |-> |wr_ff)
    else $error("present relay moved without a write");
  a_pready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("pready longer than one cycle");
  cover property (bwr);
  cover property ($fell(FAULT_ALARM_RELAY_O));
  cover property ($rose(HV_DRIVE_O));
endmodule

bind pior_top pior_top_chk #(.PERMIT_CYC(PERMIT_CYC)) u_chk (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .HV_PERMIT_INPUT_I(HV_PERMIT_INPUT_I), .HV_DRIVE_O(HV_DRIVE_O),
  .HV_PRESENT_RELAY_O(HV_PRESENT_RELAY_O), .FAULT_ALARM_RELAY_O(FAULT_ALARM_RELAY_O),
  .VOLTAGE_WINDOW_RELAY_O(VOLTAGE_WINDOW_RELAY_O),
  .BARE_CONDUCTOR_RELAY_O(BARE_CONDUCTOR_RELAY_O));

// ==== pior_contacts.sv ====
`timescale 1ns/100ps
module pior_contacts (
  // clock
  input  wire  CLK_I,
  // contacts, high = closed
  output logic permit_o,
  output logic clear_o
);
  initial begin
    permit_o = 1'b0;
    clear_o  = 1'b0;
  end
  // line stop switch: opened whenever the line halts
  task set_permit(input logic v, input int n);
    permit_o <= v;
    repeat (n) @(posedge CLK_I);
  endtask
  // momentary clear switch; short holds are used on purpose to be ignored
  task hold_clear(input int n);
    clear_o <= 1'b1;
    repeat (n) @(posedge CLK_I);
    clear_o <= 1'b0;
  endtask
endmodule

// ==== pior_top_bench.sv ====
`timescale 1ns/100ps
`include "pior_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pior_top_bench;
  logic        CLK_I = 1'b0;
  logic        SRST_I = 1'b1;
  logic        PSEL_I = 1'b0;
  logic        PENABLE_I = 1'b0;
  logic        PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0000_0000;
  wire  [31:0] PRDATA_O;
  wire         PREADY_O, PSLVERR_O, HV_DRIVE_O, HV_PRESENT_RELAY_O, IRQ_O;
  wire         FAULT_ALARM_RELAY_O, VOLTAGE_WINDOW_RELAY_O, BARE_CONDUCTOR_RELAY_O;
  wire         permit, clear;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic        se;
  always #50 CLK_I = ~CLK_I;
  pior_contacts u_sw (.CLK_I(CLK_I), .permit_o(permit), .clear_o(clear));
  pior_top #(.CLEAR_CYC(20), .PERMIT_CYC(10)) uut (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .HV_PERMIT_INPUT_I(permit),
    .REMOTE_CLEAR_INPUT_I(clear), .HV_DRIVE_O(HV_DRIVE_O),
    .HV_PRESENT_RELAY_O(HV_PRESENT_RELAY_O), .FAULT_ALARM_RELAY_O(FAULT_ALARM_RELAY_O),
    .VOLTAGE_WINDOW_RELAY_O(VOLTAGE_WINDOW_RELAY_O),
    .BARE_CONDUCTOR_RELAY_O(BARE_CONDUCTOR_RELAY_O), .IRQ_O(IRQ_O));
  // ---------------------------------------------------------------
  // common tasks
  // ---------------------------------------------------------------
  task stop_test;
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    // whole sequence needs well under this many cycles
    if (cyc > 60000) begin
      err_total++;
      stop_test;
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1'b1; PENABLE_I <= 1'b0; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    @(posedge CLK_I);
    while (PREADY_O !== 1'b1) @(posedge CLK_I);
    rd = PRDATA_O;
    se = PSLVERR_O;
    PSEL_I <= 1'b0; PENABLE_I <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge CLK_I);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    apb(0, `PIOR_OFF_WIN_HIGH, 0); `CHK(rd, 32'h0000_FFFF)
    apb(0, `PIOR_OFF_FHOLD, 0); `CHK(rd, 32'h0000_000A)
    apb(0, 12'h028, 0); `CHK({se, rd}, 33'h0_0000_0000 | (33'h1 << 32))
  endtask
  task t_levels;
    apb(1, `PIOR_OFF_VOLTAGE, 500); wt(4); `CHK(HV_PRESENT_RELAY_O, 1'b0)
    apb(1, `PIOR_OFF_VOLTAGE, 501); wt(4); `CHK(HV_PRESENT_RELAY_O, 1'b1)
    apb(1, `PIOR_OFF_WIN_LOW, 100); apb(1, `PIOR_OFF_WIN_HIGH, 600);
    apb(1, `PIOR_OFF_VOLTAGE, 99); wt(4); `CHK(VOLTAGE_WINDOW_RELAY_O, 1'b0)
    apb(1, `PIOR_OFF_VOLTAGE, 100); wt(4); `CHK(VOLTAGE_WINDOW_RELAY_O, 1'b1)
    apb(1, `PIOR_OFF_VOLTAGE, 600); wt(4); `CHK(VOLTAGE_WINDOW_RELAY_O, 1'b1)
    apb(1, `PIOR_OFF_VOLTAGE, 601); wt(4); `CHK(VOLTAGE_WINDOW_RELAY_O, 1'b0)
  endtask
  task t_permit;
    u_sw.set_permit(1, 5); u_sw.set_permit(0, 3); u_sw.set_permit(1, 6);
    `CHK(HV_DRIVE_O, 1'b0)
    wt(20); `CHK(HV_DRIVE_O, 1'b1)
    u_sw.set_permit(0, 25); `CHK(HV_DRIVE_O, 1'b0)
  endtask
  task t_latched(input logic [1:0] m);
    apb(1, `PIOR_OFF_CTRL, {30'h0, m});
    apb(1, `PIOR_OFF_FAULT, 32'h0000_0002); wt(4);
    `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b11)
    wt(60); `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b11)
    u_sw.hold_clear(10); wt(15);
    `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b11)
    u_sw.hold_clear(30); wt(5);
    `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b00)
    // sticky flags: clear accepted, permit change, bare fault
    apb(0, `PIOR_OFF_IRQ_STAT, 0); `CHK(rd[3:1], 3'b111)
  endtask
  task t_irq;
    apb(1, `PIOR_OFF_IRQ_STAT, 32'h0000_000F); apb(1, `PIOR_OFF_IRQ_MASK, 32'h0000_0001);
    wt(3); `CHK(IRQ_O, 1'b0)
    apb(1, `PIOR_OFF_FAULT, 32'h0000_0001); wt(4); `CHK(IRQ_O, 1'b1)
    apb(0, `PIOR_OFF_IRQ_STAT, 0); `CHK(rd[0], 1'b1)
    apb(1, `PIOR_OFF_IRQ_MASK, 0); wt(3); `CHK(IRQ_O, 1'b0)
    apb(1, `PIOR_OFF_IRQ_MASK, 32'h0000_0001); wt(3); `CHK(IRQ_O, 1'b1)
    apb(1, `PIOR_OFF_IRQ_STAT, 32'h0000_0001); wt(3); `CHK(IRQ_O, 1'b0)
    apb(1, `PIOR_OFF_FAULT, 32'h0000_0004); wt(4); `CHK(FAULT_ALARM_RELAY_O, 1'b0)
  endtask
  task t_timed;
    apb(1, `PIOR_OFF_CTRL, {30'h0, `PIOR_MODE_TIMED});
    apb(1, `PIOR_OFF_FHOLD, 2); apb(1, `PIOR_OFF_BHOLD, 4);
    apb(1, `PIOR_OFF_FAULT, 32'h0000_0002); wt(10);
    `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b11)
    // a clear closure is ignored in this mode, the hold time alone decides
    u_sw.hold_clear(30); wt(4);
    `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b11)
    // the first tick may come at once, so each hold may end one ms early
    wt(2 * `PIOR_MS_DIV);
    `CHK({FAULT_ALARM_RELAY_O, BARE_CONDUCTOR_RELAY_O}, 2'b01)
    wt(2 * `PIOR_MS_DIV); `CHK(BARE_CONDUCTOR_RELAY_O, 1'b0)
  endtask
  initial begin
    wt(16);
    SRST_I <= 1'b0;
    t_regs;
    t_levels;
    t_permit;
    t_latched(`PIOR_MODE_LATCHED);
    t_latched(`PIOR_MODE_LATCHALT);
    // the unused mode code behaves as latched
    t_latched(2'b11);
    t_irq;
    t_timed;
    stop_test;
  end
endmodule
